// *** design/spm_ctrl.sv ***
// Module: sleep and idle power-mode controller of the processor core
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Sleep instruction: idle_select 0 sleeps, 1 idles
// - Sleep entry clears watchdog; runs if configured
// - Sleep entry clears powerdown_flag, sets timeout_flag
// - Sleep stops CPU and system clocks and clock_output_pin
// - System-clocked conversion abandoned; dedicated continues
// - Ports hold pre-Sleep drive state, except async_pin_mask bits
// - Pin, brownout, poweron reset; others resume
// - Prefetch PC plus one during sleep
// - Wake needs individual enable, ignores global enable
// - Run next instruction, then vector if enabled
// - Every wake clears the watchdog
// - Pending enabled irq, globals off: sleep is no-op
// - Irq during sleep: complete, wake immediately
// - Low-power regulator in Sleep, extra wake delay
// - Idle halts CPU and program_flash access
// - System-clock peripherals run in Idle, not in Sleep
// - clock_output_pin keeps toggling in Idle
// - Any enabled non-clkswitch irq ends Idle; idle_select unchanged
// - recover_on_irq with doze clears doze_active on Idle irq wake only
// - Idle watchdog timeout wakes, no doze change
// - Non-watchdog resets act normally in Sleep
// - idle_select is bit 7 of rate control
// - regulator_lowpower_sel is bit 1 of regulator
module spm_ctrl
  import spm_pkg::*;
#(
  parameter int unsigned OSC_WAIT  = OSC_STARTUP_PERIODS,
  parameter int unsigned STAB_WAIT = REG_STAB_CYCLES,
  parameter int unsigned IRQ_N     = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Register writes from the core
  input  wire logic             rate_ctrl_we,
  input  wire logic [7:0]       rate_ctrl_wdata,
  input  wire logic             reg_ctrl_we,
  input  wire logic [7:0]       reg_ctrl_wdata,
  input  wire logic             doze_set,
  // Core side
  input  wire logic             sleep_exec,
  input  wire logic [15:0]      pc,
  input  wire logic             global_irq_enable,
  input  wire logic             recover_on_irq,
  input  wire logic [IRQ_N-1:0] irq_flags,
  input  wire logic [IRQ_N-1:0] irq_enables,
  input  wire logic [IRQ_N-1:0] irq_is_clkswitch,
  // Reset and watchdog sources
  input  wire logic             external_reset_pin,
  input  wire logic             brownout_reset,
  input  wire logic             poweron_reset,
  input  wire logic             wdt_timeout,
  input  wire logic             wdt_run_in_sleep,
  // Clocking configuration
  input  wire logic             crystal_mode,
  input  wire logic             clock_output_pin_enable,
  input  wire logic             osc_period_tick,
  input  wire logic             adc_busy,
  input  wire logic             adc_on_dedicated_osc,
  // Pins
  input  wire logic [7:0]       port_out,
  input  wire logic [7:0]       port_oe_n,
  input  wire logic [7:0]       async_pin_mask,
  output logic      [7:0]       pin_out,
  output logic      [7:0]       pin_oe_n,
  // Status and control
  output logic                  idle_select,
  output logic                  regulator_lowpower_sel,
  output logic                  doze_active,
  output logic                  powerdown_flag_n,
  output logic                  timeout_flag_n,
  output logic                  regulator_lowpower,
  // Clock gating and core control
  output logic                  cpu_clk_en,
  output logic                  sys_clk_en,
  output logic                  flash_access_en,
  output logic                  clock_output_en,
  output logic                  wake_request,
  output logic                  wdt_clear,
  output logic                  wdt_run,
  output logic                  device_reset,
  output logic                  adc_abort,
  output logic                  prefetch_en,
  output logic      [15:0]      prefetch_addr,
  output logic                  vector_en,
  output logic      [31:0]      vector_addr
);

  // ==========================================================
  // Helpers
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = (n == 0) ? CNT_W'(1) : CNT_W'(n);
  endfunction : cyc

  // ==========================================================
  // State
  typedef struct packed {
    spm_state_e      st;
    logic            idle_sel;
    logic            lp_sel;
    logic            doze;
    logic            pd_n;
    logic            to_n;
    logic            in_sleep;
    logic            osc_wait;
    logic            osc_phase;
    logic [CNT_W-1:0] cnt;
    logic            wdt_clr;
    logic            abort;
    logic            dev_rst;
    logic            prefetch;
    logic [15:0]     pf_addr;
    logic            irq_wake;
    logic            vec;
    logic [7:0]      hold_out;
    logic [7:0]      hold_oe_n;
  } spm_state_s;

  spm_state_s s_q;
  spm_state_s s_d;

  logic any_rst;
  logic irq_wake;
  logic wake_now;

  assign any_rst  = external_reset_pin | brownout_reset | poweron_reset;
  assign irq_wake = |(irq_flags & irq_enables & ~irq_is_clkswitch);
  assign wake_now = irq_wake | wdt_timeout;

  logic sleep_noop;
  // Pending enabled irq with globals off turns sleep into a no-op
  assign sleep_noop = irq_wake & ~global_irq_enable;

  // ==========================================================
  // Wake-up wait phases
  logic cnt_zero;
  logic cnt_step;

  assign cnt_zero = (s_q.cnt == CNT_W'(0));
  // Crystal start-up counts oscillator periods; regulator counts cycles
  // Limitation: waits longer than CNT_W bits allow need a wider CNT_W
  assign cnt_step = !s_q.osc_phase || osc_period_tick;

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_d          = s_q;
    s_d.wdt_clr  = 1'b0;
    s_d.abort    = 1'b0;
    s_d.dev_rst  = 1'b0;
    s_d.prefetch = 1'b0;
    s_d.vec      = 1'b0;
    if (rate_ctrl_we) begin
      s_d.idle_sel = rate_ctrl_wdata[IDLE_SELECT_BIT];
    end
    if (reg_ctrl_we) begin
      s_d.lp_sel = reg_ctrl_wdata[REG_LOWPOWER_BIT];
    end
    if (doze_set) begin
      s_d.doze = 1'b1;
    end
    case (s_q.st)
      SPM_RUN: begin
        if (sleep_exec) begin
          s_d.prefetch = 1'b1;
          s_d.pf_addr  = pc + 16'h0001;
          if (!sleep_noop) begin
            s_d.wdt_clr = 1'b1;
            s_d.pd_n    = 1'b0;
            s_d.to_n    = 1'b1;
            if (s_q.idle_sel) begin
              s_d.st = SPM_IDLE;
            end else begin
              s_d.st        = SPM_SLEEP;
              s_d.in_sleep  = 1'b1;
              s_d.abort     = adc_busy & ~adc_on_dedicated_osc;
              s_d.hold_out  = port_out;
              s_d.hold_oe_n = port_oe_n;
            end
          end
        end
      end
      SPM_SLEEP, SPM_IDLE: begin
        // Wake sampled the cycle after entry: a late irq still wakes
        if (wake_now) begin
          s_d.wdt_clr  = 1'b1;
          s_d.irq_wake = irq_wake;
          if (s_q.st == SPM_IDLE) begin
            // Idle keeps idle_select; watchdog wake leaves doze alone
            if (irq_wake && recover_on_irq && s_q.doze) begin
              s_d.doze = 1'b0;
            end
            s_d.st = SPM_NEXT;
          end else begin
            s_d.osc_wait = crystal_mode;
            s_d.cnt      = s_q.lp_sel ? cyc(STAB_WAIT)
                                      : CNT_W'(0);
            s_d.st       = SPM_WAIT;
          end
        end
      end
      SPM_WAIT: begin
        if (!cnt_zero) begin
          // Regulator settles first, then the crystal start-up
          if (cnt_step) begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
          end
        end else if (s_q.osc_wait) begin
          s_d.osc_wait  = 1'b0;
          s_d.osc_phase = 1'b1;
          s_d.cnt       = cyc(OSC_WAIT);
        end else begin
          s_d.osc_phase = 1'b0;
          s_d.in_sleep  = 1'b0;
          s_d.st        = SPM_NEXT;
        end
      end
      SPM_NEXT: begin
        // Next instruction runs, then the vector if enabled
        s_d.vec      = s_q.irq_wake & global_irq_enable;
        s_d.irq_wake = 1'b0;
        s_d.st       = SPM_RUN;
      end
      default: begin
        s_d.st = SPM_RUN;
      end
    endcase
    // Resets other than the watchdog act in any mode
    if (any_rst) begin
      s_d          = s_q;
      s_d.st       = SPM_RUN;
      s_d.dev_rst  = 1'b1;
      s_d.in_sleep = 1'b0;
      s_d.idle_sel = IDLE_SELECT_RST;
      s_d.lp_sel   = REG_LOWPOWER_RST;
      s_d.doze     = 1'b0;
      s_d.pd_n     = POWERDOWN_RST;
      s_d.to_n     = TIMEOUT_RST;
      s_d.cnt      = CNT_W'(0);
      s_d.osc_wait = 1'b0;
      // Pulses must not stretch while a reset source stays high
      s_d.osc_phase = 1'b0;
      s_d.wdt_clr  = 1'b0;
      s_d.abort    = 1'b0;
      s_d.irq_wake = 1'b0;
      s_d.vec      = 1'b0;
      s_d.prefetch = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{
        st:        SPM_RUN,
        idle_sel:  IDLE_SELECT_RST,
        lp_sel:    REG_LOWPOWER_RST,
        doze:      1'b0,
        pd_n:      POWERDOWN_RST,
        to_n:      TIMEOUT_RST,
        in_sleep:  1'b0,
        osc_wait:  1'b0,
        osc_phase: 1'b0,
        cnt:       '0,
        wdt_clr:   1'b0,
        abort:     1'b0,
        dev_rst:   1'b0,
        prefetch:  1'b0,
        pf_addr:   '0,
        irq_wake:  1'b0,
        vec:       1'b0,
        hold_out:  '0,
        hold_oe_n: '0
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  logic halted;
  logic sleeping;

  assign halted   = (s_q.st != SPM_RUN) && (s_q.st != SPM_NEXT);
  assign sleeping = s_q.in_sleep;

  // Held bits freeze while asleep; masked bits follow async peripherals
  function automatic logic [7:0] merge_pins(input logic [7:0] held,
                                            input logic [7:0] live,
                                            input logic [7:0] mask);
    merge_pins = (held & ~mask) | (live & mask);
  endfunction : merge_pins

  // ==========================================================
  // Status outputs
  assign idle_select            = s_q.idle_sel;
  assign regulator_lowpower_sel = s_q.lp_sel;
  assign doze_active            = s_q.doze;
  assign powerdown_flag_n       = s_q.pd_n;
  assign timeout_flag_n         = s_q.to_n;

  // ==========================================================
  // Clock gating
  // Low-power regulator only while actually asleep
  assign regulator_lowpower = (s_q.st == SPM_SLEEP) & s_q.lp_sel;
  assign cpu_clk_en      = ~halted;
  assign flash_access_en = ~halted;
  assign sys_clk_en      = ~sleeping;
  assign clock_output_en = clock_output_pin_enable & ~sleeping;

  // ==========================================================
  // Core control
  assign wake_request    = irq_wake;
  assign wdt_clear       = s_q.wdt_clr;
  // Watchdog only keeps counting in Sleep when so configured
  assign wdt_run         = ~sleeping | wdt_run_in_sleep;
  assign device_reset    = s_q.dev_rst;
  assign adc_abort       = s_q.abort;
  assign prefetch_en     = s_q.prefetch;
  assign prefetch_addr   = s_q.pf_addr;
  assign vector_en       = s_q.vec;
  assign vector_addr     = IRQ_VECTOR;

  // ==========================================================
  // Pins
  // Async peripherals may still move their pins while asleep
  assign pin_out  = sleeping ? merge_pins(s_q.hold_out, port_out,
                                          async_pin_mask)
                             : port_out;
  assign pin_oe_n = sleeping ? merge_pins(s_q.hold_oe_n, port_oe_n,
                                          async_pin_mask)
                             : port_oe_n;

endmodule : spm_ctrl

`default_nettype wire

// *** design/spm_pkg.sv ***
// Package: constants and types for the sleep/idle power-mode controller
package spm_pkg;
  // ==========================================================
  // Register bit positions
  localparam int unsigned IDLE_SELECT_BIT   = 7;
  localparam int unsigned REG_LOWPOWER_BIT  = 1;
  // ==========================================================
  // Reset values
  localparam logic        IDLE_SELECT_RST   = 1'h0;
  localparam logic        REG_LOWPOWER_RST  = 1'h0;
  localparam logic        POWERDOWN_RST     = 1'h1;
  localparam logic        TIMEOUT_RST       = 1'h1;
  // ==========================================================
  // Timing
  localparam int unsigned OSC_STARTUP_PERIODS = 1024;
  localparam int unsigned REG_STAB_CYCLES     = 64;
  localparam logic [31:0] IRQ_VECTOR          = 32'h0000_0004;
  localparam int unsigned CNT_W               = 16;

  // ==========================================================
  // Power-mode state machine
  typedef enum logic [2:0] {
    SPM_RUN   = 3'h0,
    SPM_SLEEP = 3'h1,
    SPM_IDLE  = 3'h3,
    SPM_WAIT  = 3'h2,
    SPM_NEXT  = 3'h6
  } spm_state_e;
endpackage : spm_pkg

// *** sim/spm_ctrl_checker.sv ***
// Checker: port assertions of the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module spm_ctrl_checker
  import spm_pkg::*;
(
  input wire logic        ref_clk, rst_n, sleep_exec, cpu_clk_en,
  input wire logic        sys_clk_en, wake_request, global_irq_enable,
  input wire logic        wdt_timeout, recover_on_irq, idle_select,
  input wire logic        regulator_lowpower, regulator_lowpower_sel,
  input wire logic        powerdown_flag_n, timeout_flag_n, wdt_clear,
  input wire logic        prefetch_en, vector_en, doze_active,
  input wire logic        device_reset, external_reset_pin,
  input wire logic        brownout_reset, poweron_reset,
  input wire logic [15:0] pc, prefetch_addr,
  input wire logic [31:0] vector_addr
);
  wire logic rst_in = external_reset_pin | brownout_reset | poweron_reset;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Steps
  sequence take_s;
    sleep_exec && cpu_clk_en && $past(cpu_clk_en) && !rst_in;
  endsequence
  sequence idle_s;
    !cpu_clk_en && sys_clk_en && !rst_in;
  endsequence
  chk_sleep_entry: assert property (take_s ##0 !wake_request |=>
    !cpu_clk_en && !powerdown_flag_n && timeout_flag_n && wdt_clear)
    else $error("sleep entry wrong");
  chk_mode_select: assert property (take_s ##0 !wake_request |=>
    sys_clk_en == idle_select) else $error("mode select wrong");
  chk_sleep_noop: assert property (take_s ##0 wake_request &&
    !global_irq_enable |=> cpu_clk_en && !wdt_clear &&
    $stable(powerdown_flag_n) && $stable(timeout_flag_n))
    else $error("noop sleep wrong");
  chk_prefetch_addr: assert property (take_s |=> prefetch_en &&
    prefetch_addr == $past(pc) + 16'h1) else $error("prefetch wrong");
  chk_idle_wake: assert property (idle_s ##0 (wake_request ||
    wdt_timeout) |=> wdt_clear && cpu_clk_en ##1 cpu_clk_en)
    else $error("idle wake wrong");
  chk_wdt_doze: assert property (idle_s ##0 wdt_timeout &&
    !wake_request |=> $stable(doze_active)) else $error("doze changed");
  chk_roi_clear: assert property (idle_s ##0 wake_request &&
    recover_on_irq && doze_active |-> ##[1:2] !doze_active)
    else $error("doze not cleared");
  chk_reset_src: assert property (rst_in |=> device_reset)
    else $error("reset source ignored");
  chk_vector_addr: assert property (vector_en |->
    global_irq_enable && vector_addr == IRQ_VECTOR)
    else $error("vector wrong");
  chk_reg_lowpower: assert property (regulator_lowpower |->
    regulator_lowpower_sel && !sys_clk_en) else $error("lp wrong");
endmodule : spm_ctrl_checker
bind spm_ctrl spm_ctrl_checker u_chk (.*);
`default_nettype wire

// *** sim/spm_ctrl_tb.sv ***
// Testbench: sequences of core requests against the controller
`timescale 1ns/1ps
`default_nettype none
module spm_ctrl_tb;
  import spm_pkg::*;
  localparam int W = 4;
  logic ref_clk, rst_n, rate_ctrl_we, reg_ctrl_we, doze_set, sleep_exec;
  logic global_irq_enable, recover_on_irq, external_reset_pin;
  logic brownout_reset, poweron_reset, wdt_timeout, wdt_run_in_sleep;
  logic crystal_mode, clock_output_pin_enable, osc_period_tick, adc_busy;
  logic adc_on_dedicated_osc, idle_select, regulator_lowpower_sel;
  logic doze_active, powerdown_flag_n, timeout_flag_n, regulator_lowpower;
  logic cpu_clk_en, sys_clk_en, flash_access_en, clock_output_en;
  logic wake_request, wdt_clear, wdt_run, device_reset, adc_abort;
  logic prefetch_en, vector_en, vec_seen;
  logic [7:0] rate_ctrl_wdata, reg_ctrl_wdata, irq_flags, irq_enables;
  logic [7:0] irq_is_clkswitch, port_out, port_oe_n, async_pin_mask;
  logic [7:0] pin_out, pin_oe_n;
  logic [15:0] pc, prefetch_addr;
  logic [31:0] vector_addr;
  int miscompares, compares, n;
  spm_ctrl #(.OSC_WAIT(W), .STAB_WAIT(W)) dut (.*);
  spm_osc_model u_osc (.ref_clk(ref_clk), .rst_n(rst_n),
                       .osc_period_tick(osc_period_tick));
  always #2.5 ref_clk = ~ref_clk;
  // ==========================================================
  // Tasks
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc
  task wr(input logic rg, input logic [7:0] d);
    @(negedge ref_clk) {rate_ctrl_we, reg_ctrl_we} = {!rg, rg};
    {rate_ctrl_wdata, reg_ctrl_wdata} = {d, d};
    @(negedge ref_clk) {rate_ctrl_we, reg_ctrl_we} = 2'h0;
  endtask : wr
  task pulse_doze;
    @(negedge ref_clk) doze_set = 1'b1;
    @(negedge ref_clk) doze_set = 1'b0;
  endtask : pulse_doze
  task sleep_op(input logic [15:0] a);
    @(negedge ref_clk) sleep_exec = 1'b1;
    pc = a;
    @(negedge ref_clk) sleep_exec = 1'b0;
  endtask : sleep_op
  // Bounded wait for the core clock, then two cycles for the vector
  task wake_wait;
    n = 0;
    vec_seen = 1'b0;
    while (cpu_clk_en !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    repeat (2) begin
      cyc(1);
      vec_seen |= vector_en;
    end
    chk(n < 200, "no wake");
  endtask : wake_wait
  task finish_test;
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end
  // ==========================================================
  // Scenarios
  initial begin
    {ref_clk, rst_n, rate_ctrl_we, reg_ctrl_we, doze_set} = 5'h0;
    {sleep_exec, global_irq_enable, recover_on_irq, wdt_timeout} = 4'h0;
    {external_reset_pin, brownout_reset, poweron_reset} = 3'h0;
    {wdt_run_in_sleep, crystal_mode, adc_busy} = 3'h0;
    {adc_on_dedicated_osc, clock_output_pin_enable} = 2'h1;
    {rate_ctrl_wdata, reg_ctrl_wdata, irq_flags} = 24'h0;
    {irq_enables, irq_is_clkswitch, async_pin_mask} = 24'h010000;
    {port_out, port_oe_n, pc} = 32'h5A000000;
    miscompares = 0;
    compares = 0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    chk(powerdown_flag_n & timeout_flag_n & !idle_select, "reset");
    irq_flags = 8'h01;
    sleep_op(16'h0100);
    chk(cpu_clk_en & powerdown_flag_n & prefetch_en, "noop");
    chk(prefetch_addr === 16'h0101, "prefetch");
    irq_flags = 8'h00;
    adc_busy = 1'b1;
    sleep_op(16'h0200);
    chk(!sys_clk_en & !cpu_clk_en & !powerdown_flag_n, "sleep");
    chk(adc_abort === 1'b1, "adc not aborted");
    {irq_flags, port_out} = 16'h02A5;
    cyc(5);
    chk(!cpu_clk_en & timeout_flag_n, "woke on disabled irq");
    chk(pin_out === 8'h5A && wdt_run === 1'b0, "pins not held");
    irq_flags = 8'h03;
    wake_wait();
    chk(!vec_seen, "vector with global off");
    {irq_flags, crystal_mode, global_irq_enable} = 10'h003;
    wr(1'b1, 8'h02);
    sleep_op(16'h0300);
    chk(regulator_lowpower, "low power off");
    irq_flags = 8'h01;
    wake_wait();
    chk(n >= W + W && vec_seen, "wake delays");
    {irq_flags, crystal_mode} = 9'h0;
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h80);
    pulse_doze();
    recover_on_irq = 1'b1;
    sleep_op(16'h0400);
    chk(sys_clk_en & !flash_access_en & clock_output_en, "idle");
    irq_flags = 8'h01;
    wake_wait();
    chk(!doze_active & idle_select & vec_seen, "idle irq");
    {irq_flags, global_irq_enable} = 9'h0;
    pulse_doze();
    sleep_op(16'h0500);
    @(negedge ref_clk) wdt_timeout = 1'b1;
    @(negedge ref_clk) wdt_timeout = 1'b0;
    wake_wait();
    chk(doze_active & !device_reset, "idle wdt");
    wr(1'b0, 8'h00);
    sleep_op(16'h0600);
    brownout_reset = 1'b1;
    n = 0;
    while (device_reset !== 1'b1 && n < 4) begin
      cyc(1);
      n++;
    end
    chk(device_reset, "brownout ignored");
    brownout_reset = 1'b0;
    cyc(4);
    finish_test();
  end
endmodule : spm_ctrl_tb
`default_nettype wire

// *** sim/spm_osc_model.sv ***
// Partner model: oscillator giving one tick per period
`timescale 1ns/1ps
`default_nettype none
module spm_osc_model #(
  parameter int unsigned DIV = 3
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  output logic      osc_period_tick
);
  logic [3:0] cnt_q;
  // Crystal is slower than ref_clk, so ticks are sparse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q           <= 4'h0;
      osc_period_tick <= 1'b0;
    end else begin
      cnt_q           <= (cnt_q == 4'(DIV-1)) ? 4'h0 : cnt_q + 4'h1;
      osc_period_tick <= (cnt_q == 4'(DIV-1));
    end
  end
endmodule : spm_osc_model
`default_nettype wire
